// file: rtl/cba_defs.svh
// Constants for the CPU bus access timing block
`ifndef CBA_DEFS_SVH
`define CBA_DEFS_SVH
`define CBA_SLOW_CYCLES 2'h2
`define CBA_FAST_CYCLES 2'h1
`define CBA_SFR_BASE 16'h0000
`define CBA_SFR_LAST 16'h02FF
`define CBA_RAM_BASE 16'h0400
`define CBA_RAM_LAST 16'h0FFF
`define CBA_DFL_BASE 16'h2400
`define CBA_DFL_LAST 16'h2BFF
`define CBA_ROM_BASE 16'h4000
`define CBA_ROM_LAST 16'hFFFF
`define CBA_TMR_CNT_ADDR 16'h0126
`define CBA_TMR_GRA_ADDR 16'h0128
`define CBA_TMR_GRB_ADDR 16'h012A
`define CBA_TMR_GRC_ADDR 16'h012C
`define CBA_TMR_GRD_ADDR 16'h012E
`endif

// file: rtl/cba_pkg.sv
// Types for the CPU bus access timing block
package cba_pkg;
  typedef enum logic [2:0] {
    CBA_NONE = 3'h0,
    CBA_SFR = 3'h1,
    CBA_RAM = 3'h2,
    CBA_ROM = 3'h3,
    CBA_DFL = 3'h4
  } cba_region_t;
  typedef enum logic [1:0] {
    CBA_IDLE = 2'h0,
    CBA_LOW = 2'h1,
    CBA_HIGH = 2'h3
  } cba_state_t;
endpackage

// file: rtl/cba_decode.sv
// Address region decoder with cycle length and wide-path flag
`include "cba_defs.svh"
module cba_decode
  import cba_pkg::*;
#(
  parameter bit HAS_DATA_FLASH = 1'b1
) (
  // Address
  input wire logic [15:0] addr,
  // Decode result
  output cba_region_t region,
  output logic [1:0] cycles,
  output logic wide_path
);
  // Region decode, only on-chip areas exist
  always_comb begin
    region = CBA_NONE;
    if (addr <= `CBA_SFR_LAST) region = CBA_SFR;
    else if (addr >= `CBA_RAM_BASE && addr <= `CBA_RAM_LAST) region = CBA_RAM;
    else if (HAS_DATA_FLASH && addr >= `CBA_DFL_BASE && addr <= `CBA_DFL_LAST) region = CBA_DFL;
    else if (addr >= `CBA_ROM_BASE) region = CBA_ROM;
  end
  // Slow for SFR and data flash, fast otherwise
  always_comb begin
    if (region == CBA_SFR || region == CBA_DFL) cycles = `CBA_SLOW_CYCLES;
    else cycles = `CBA_FAST_CYCLES;
  end
  // Timer registers on the 16-bit path
  assign wide_path = (addr == `CBA_TMR_CNT_ADDR) || (addr == `CBA_TMR_GRA_ADDR) ||
    (addr == `CBA_TMR_GRB_ADDR) || (addr == `CBA_TMR_GRC_ADDR) || (addr == `CBA_TMR_GRD_ADDR);
endmodule // cba_decode

// file: rtl/cba_bus.sv
// CPU bus access sequencer: region timing and word splitting
// Functional notes
// - SFR and data flash accesses take two cycles
// - RAM and program ROM take one cycle
// - Decode region, cycle length differs per region
// - Memory and SFR data path 8 bits
// - Word access becomes two byte accesses
// - Timer counter and general registers 16-bit
// - Timer word in one even-byte SFR access
// - Only SFR, RAM, data flash, ROM reachable
`include "cba_defs.svh"
module cba_bus
  import cba_pkg::*;
#(
  parameter bit HAS_DATA_FLASH = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Core request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_word,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  // Byte path
  output logic mem_en,
  output logic mem_write,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Timer word path
  output logic tmr_en,
  output logic tmr_write,
  output logic [15:0] tmr_addr,
  output logic [15:0] tmr_wdata,
  input wire logic [15:0] tmr_rdata
);
  cba_state_t state_reg;
  logic [1:0] cnt_reg;
  logic [1:0] len_reg;
  logic wide_reg, word_reg, write_reg, done_reg;
  logic [15:0] addr_reg, wdata_reg, rdata_reg;
  cba_region_t dec_region;
  logic [1:0] dec_cycles;
  logic dec_wide;
  logic [15:0] byte_addr;
  logic last_cyc;

  // Region decode of the current request
  cba_decode #(.HAS_DATA_FLASH(HAS_DATA_FLASH)) u_dec (
    .addr(state_reg == CBA_IDLE ? req_addr : byte_addr),
    .region(dec_region),
    .cycles(dec_cycles),
    .wide_path(dec_wide)
  );

  assign req_ready = (state_reg == CBA_IDLE);
  assign last_cyc = (cnt_reg == len_reg);
  // High byte at the odd address
  assign byte_addr = (state_reg == CBA_HIGH) ? (addr_reg | 16'h0001) : addr_reg;

  // Sequencer: capture, even byte, then odd byte
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= CBA_IDLE;
      cnt_reg <= 2'h1;
      len_reg <= 2'h1;
      wide_reg <= 1'b0;
      word_reg <= 1'b0;
      write_reg <= 1'b0;
      addr_reg <= 16'h0000;
      wdata_reg <= 16'h0000;
    end else if (clk_en) begin
      unique case (state_reg)
        CBA_IDLE: begin
          if (req_valid) begin
            state_reg <= CBA_LOW;
            cnt_reg <= 2'h1;
            len_reg <= dec_cycles;
            wide_reg <= req_word && dec_wide;
            word_reg <= req_word;
            write_reg <= req_write;
            addr_reg <= req_addr;
            wdata_reg <= req_wdata;
          end
        end
        CBA_LOW: begin
          if (!last_cyc) cnt_reg <= cnt_reg + 2'h1;
          else if (word_reg && !wide_reg) begin
            state_reg <= CBA_HIGH;
            cnt_reg <= 2'h1;
            len_reg <= dec_cycles;
          end else state_reg <= CBA_IDLE;
        end
        CBA_HIGH: begin
          if (!last_cyc) cnt_reg <= cnt_reg + 2'h1;
          else state_reg <= CBA_IDLE;
        end
      endcase
    end
  end

  // Read data gathering and completion pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
      done_reg <= 1'b0;
    end else if (clk_en) begin
      done_reg <= 1'b0;
      if (state_reg != CBA_IDLE && last_cyc) begin
        if (wide_reg) rdata_reg <= tmr_rdata;
        else if (dec_region == CBA_NONE) rdata_reg <= 16'h0000;
        else if (state_reg == CBA_HIGH) rdata_reg[15:8] <= mem_rdata;
        else rdata_reg <= {8'h00, mem_rdata};
        done_reg <= !(state_reg == CBA_LOW && word_reg && !wide_reg);
      end
    end
  end

  // Byte and timer strobes, active in the final cycle of each access
  always_comb begin
    mem_en = (state_reg != CBA_IDLE) && !wide_reg && last_cyc && (dec_region != CBA_NONE);
    mem_write = write_reg;
    mem_addr = byte_addr;
    mem_wdata = (state_reg == CBA_HIGH) ? wdata_reg[15:8] : wdata_reg[7:0];
    tmr_en = (state_reg == CBA_LOW) && wide_reg && last_cyc;
    tmr_write = write_reg;
    tmr_addr = addr_reg;
    tmr_wdata = wdata_reg;
  end

  assign rsp_valid = done_reg;
  assign rsp_rdata = rdata_reg;

  // Assertions

  // Slow byte: one wait cycle, then the strobe
  a_sfr_two_cycles: assert property (@(posedge core_clk) disable iff (rst)
    (req_valid && req_ready && clk_en && !req_word && dec_region != CBA_NONE &&
      dec_cycles == `CBA_SLOW_CYCLES) ##1 clk_en |-> !mem_en ##1 mem_en)
    else $error("slow access length wrong");

  // Fast byte: strobe right after the take
  a_fast_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    (req_valid && req_ready && clk_en && !req_word && dec_region != CBA_NONE &&
      dec_cycles == `CBA_FAST_CYCLES) |=> mem_en)
    else $error("fast access not one cycle");

  // Odd byte comes in the second half
  a_split_order: assert property (@(posedge core_clk) disable iff (rst)
    (mem_en && state_reg == CBA_HIGH) |-> mem_addr[0])
    else $error("odd byte not second");

  // Timer word goes out in one access
  a_timer_single: assert property (@(posedge core_clk) disable iff (rst)
    (tmr_en && clk_en) |=> (state_reg == CBA_IDLE))
    else $error("timer word split");

  // Completion is a single pulse
  a_rsp_pulse: assert property (@(posedge core_clk) disable iff (rst)
    rsp_valid && clk_en |=> !rsp_valid)
    else $error("response held too long");

  // Never both paths in one cycle
  a_no_overlap: assert property (@(posedge core_clk) disable iff (rst)
    !(mem_en && tmr_en))
    else $error("both paths active");

  // No strobe while waiting for a request
  a_ready_idle: assert property (@(posedge core_clk) disable iff (rst)
    req_ready |-> !mem_en && !tmr_en)
    else $error("strobe while idle");

  // Wait counter stays inside the access length
  a_len_bound: assert property (@(posedge core_clk) disable iff (rst)
    cnt_reg <= len_reg)
    else $error("cycle counter overran");

  // Length latched matches the region being accessed
  a_region_len: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg != CBA_IDLE) |-> (len_reg == dec_cycles))
    else $error("length differs from region");

  // Split word moves on to the odd byte
  a_word_second: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == CBA_LOW && last_cyc && word_reg && !wide_reg && clk_en) |=> (state_reg == CBA_HIGH))
    else $error("word not split");

  // Odd byte address pairs with the even one
  a_word_pair: assert property (@(posedge core_clk) disable iff (rst)
    (mem_en && state_reg == CBA_HIGH) |-> (mem_addr == (addr_reg | 16'h0001)))
    else $error("odd byte address wrong");

  // Even byte carries the low data byte
  a_low_byte_data: assert property (@(posedge core_clk) disable iff (rst)
    (mem_en && state_reg == CBA_LOW) |-> (mem_wdata == wdata_reg[7:0]))
    else $error("low byte data wrong");

  // Timer path only at even addresses
  a_timer_even: assert property (@(posedge core_clk) disable iff (rst)
    tmr_en |-> !tmr_addr[0])
    else $error("timer access at odd address");

  // Unmapped addresses never strobe memory
  a_unmapped_quiet: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg != CBA_IDLE && dec_region == CBA_NONE) |-> !mem_en)
    else $error("strobe to unmapped address");

  // Wide path only for word requests
  a_wide_needs_word: assert property (@(posedge core_clk) disable iff (rst)
    wide_reg |-> word_reg)
    else $error("wide path on byte access");

  // Completion leaves the sequencer ready
  a_idle_on_rsp: assert property (@(posedge core_clk) disable iff (rst)
    rsp_valid |-> req_ready)
    else $error("busy at completion");

  // Low clock enable freezes the sequencer
  a_freeze_state: assert property (@(posedge core_clk) disable iff (rst)
    !clk_en |=> ($stable(state_reg) && $stable(cnt_reg)))
    else $error("state moved while frozen");

  // Main scenarios
  c_word_split: cover property (@(posedge core_clk) state_reg == CBA_HIGH && mem_en);
  c_timer_word: cover property (@(posedge core_clk) tmr_en);
  c_slow_byte: cover property (@(posedge core_clk) mem_en && len_reg == `CBA_SLOW_CYCLES);
  c_slow_word: cover property (@(posedge core_clk) state_reg == CBA_HIGH && mem_en && len_reg == `CBA_SLOW_CYCLES);
  c_unmapped: cover property (@(posedge core_clk) state_reg != CBA_IDLE && dec_region == CBA_NONE);
endmodule // cba_bus

// file: bench/cba_mem_model.sv
// Byte memory and timer word registers on the far side of the sequencer
module cba_mem_model (
  // Clock
  input wire logic core_clk,
  // Byte path
  input wire logic mem_en,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata,
  // Timer word path
  input wire logic tmr_en,
  input wire logic [15:0] tmr_addr,
  output logic [15:0] tmr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] noise_reg = 16'h0000;
  // Changing pattern while unselected, so stale data never looks valid
  always @(posedge core_clk) noise_reg <= noise_reg + 16'h3B1D;
  // Data derived from the address
  assign mem_rdata = mem_en ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5A) : noise_reg[7:0];
  assign tmr_rdata = tmr_en ? (tmr_addr ^ 16'hA5C3) : ~noise_reg;
endmodule // cba_mem_model

// file: bench/cba_bus_bench.sv
// Self-checking bench for the CPU bus access sequencer
module cba_bus_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_word = 1'b0;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000;
  logic req_ready, rsp_valid, mem_en, mem_write, tmr_en, tmr_write;
  logic [15:0] rsp_rdata, mem_addr, tmr_addr, tmr_wdata, tmr_rdata;
  logic [7:0] mem_wdata, mem_rdata;
  logic [33:0] strb_q[$];
  logic [56:0] rsp_q[$];
  logic [33:0] e;
  logic [56:0] r;
  logic [15:0] bnd[10] = '{16'h0010, 16'h02FE, 16'h0400, 16'h0FFE, 16'h2400, 16'h2BFE, 16'h4000, 16'hFFFE,
    16'h0300, 16'h1000};
  int failures = 0, cmp_count = 0, cyc = 0, seed, i;
  // Clock
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  cba_bus u_dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_word(req_word), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_en(mem_en), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .tmr_en(tmr_en), .tmr_write(tmr_write), .tmr_addr(tmr_addr),
    .tmr_wdata(tmr_wdata), .tmr_rdata(tmr_rdata));
  cba_mem_model u_mem (.core_clk(core_clk), .mem_en(mem_en), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .tmr_en(tmr_en), .tmr_addr(tmr_addr), .tmr_rdata(tmr_rdata));
  // Compare and count
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("wrong value at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [7:0] bf(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  // One core request: note expected strobes, hold until taken, then note the answer
  task automatic access(input logic w, input logic wd, input logic [15:0] a, input logic [15:0] d);
    logic s, f, t;
    logic [7:0] lat;
    int n;
    s = a <= 16'h02FF || (a >= 16'h2400 && a <= 16'h2BFF);
    f = (a >= 16'h0400 && a <= 16'h0FFF) || a >= 16'h4000;
    t = wd && a >= 16'h0126 && a <= 16'h012E && !a[0];
    lat = t ? 8'h03 : wd ? (s ? 8'h05 : 8'h03) : (s ? 8'h03 : 8'h02);
    if (t) strb_q.push_back({1'b1, w, a, d});
    else if (s || f) begin
      strb_q.push_back({1'b0, w, a, 8'h00, d[7:0]});
      if (wd) strb_q.push_back({1'b0, w, a | 16'h0001, 8'h00, d[15:8]});
    end
    req_valid = 1'b1;
    req_write = w;
    req_word = wd;
    req_addr = a;
    req_wdata = d;
    for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(posedge core_clk) #1;
    if (n == 20) begin
      failures++;
      complete_run();
    end
    @(posedge core_clk) #1;
    rsp_q.push_back({!w, t ? a ^ 16'hA5C3 : !(s || f) ? 16'h0000 : {wd ? bf(a | 16'h0001) : 8'h00, bf(a)}, lat, cyc});
  endtask
  // Watch strobes and answers against the oldest notes
  always @(posedge core_clk) begin
    #2;
    if (mem_en === 1'b1 || tmr_en === 1'b1) begin
      if (strb_q.size() == 0) check(32'h1, 32'h0);
      e = strb_q.size() ? strb_q.pop_front() : 34'h0;
      check(tmr_en, e[33]);
      check(tmr_en ? tmr_write : mem_write, e[32]);
      check(tmr_en ? tmr_addr : mem_addr, e[31:16]);
      if (e[32]) check(tmr_en ? tmr_wdata : {8'h00, mem_wdata}, e[15:0]);
    end
    if (rsp_valid === 1'b1) begin
      if (rsp_q.size() == 0) check(32'h1, 32'h0);
      r = rsp_q.size() ? rsp_q.pop_front() : 57'h0;
      if (r[39:32] != 8'h00) check(cyc + 1 - r[31:0], r[39:32]);
      if (r[56]) check(rsp_rdata, r[55:40]);
    end
  end
  // Region boundaries, timer words, then random traffic back to back
  initial begin
    seed = 86;
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    foreach (bnd[k])
      for (i = 0; i < 4; i++) access(i[0], i[1], bnd[k], 16'hC3A5);
    for (i = 0; i < 15; i++) access(i % 3 == 1, i % 3 != 2, 16'h0126 + 16'(2 * (i / 3)), 16'h9E61);
    for (i = 0; i < 40; i++) access(1'($random(seed)), i[0], 16'($random(seed)) & {15'h7FFF, !i[0]}, 16'($random(seed)));
    req_valid = 1'b0;
    repeat (8) @(posedge core_clk);
    check(strb_q.size() + rsp_q.size(), 0);
    complete_run();
  end
endmodule // cba_bus_bench
